// File: verilog/slc_pkg.sv
package slc_pkg;

	// Device register indices on its own register port
	localparam logic [3:0] DEV_CMD     = 4'h0;
	localparam logic [3:0] DEV_RXPAR   = 4'h3;
	localparam logic [3:0] DEV_MODE    = 4'h4;
	localparam logic [3:0] DEV_TXPAR   = 4'h5;
	localparam logic [3:0] DEV_STADDR  = 4'h6;
	localparam logic [3:0] DEV_FLAGPAT = 4'h7;
	localparam logic [3:0] DEV_TXBUF   = 4'h8;
	localparam logic [3:0] DEV_MISC    = 4'hA;
	localparam logic [3:0] DEV_PSTAT   = 4'h0;
	localparam logic [3:0] DEV_MSTAT   = 4'hA;

	// Fixed register values and the flag pattern reset value
	localparam logic [7:0] MODE_LOOP_VAL  = 8'h20;
	localparam logic [7:0] CMD_RST_TXCRC  = 8'h80;
	localparam logic [7:0] FLAG_RESET_VAL = 8'h7E;

	// Bit positions
	localparam int MISC_CRC_PRESET = 7;
	localparam int MISC_ENC_LO     = 5;
	localparam int MISC_POLL       = 4;
	localparam int MISC_IDLE       = 3;
	localparam int MISC_LOOP       = 1;
	localparam int RXP_HUNT        = 4;
	localparam int RXP_CRC         = 3;
	localparam int RXP_ASRCH       = 2;
	localparam int RXP_ENABLE      = 0;
	localparam int TXP_DTR         = 7;
	localparam int TXP_BITS_LO     = 5;
	localparam int TXP_ENABLE      = 3;
	localparam int TXP_RTS         = 1;
	localparam int TXP_CRC_EN      = 0;
	localparam int PST_BREAK       = 7;
	localparam int PST_HUNT        = 4;
	localparam int PST_TXEMPTY     = 2;
	localparam int MST_SENDING     = 4;
	localparam int MST_ONLOOP      = 1;

	// Software-facing register byte addresses
	localparam logic [7:0] WB_CTRL   = 8'h00;
	localparam logic [7:0] WB_CFG    = 8'h04;
	localparam logic [7:0] WB_ADDR   = 8'h08;
	localparam logic [7:0] WB_TXDATA = 8'h0C;
	localparam logic [7:0] WB_STATUS = 8'h10;
	localparam int CTRL_INIT  = 0;
	localparam int CTRL_SEND  = 1;
	localparam int CTRL_LEAVE = 2;
	localparam int TXD_LAST   = 8;
	localparam logic [9:0] CFG_RESET_VAL = 10'h000;

	// Device port timing
	localparam int CLK_PERIOD_PS   = 5000;
	localparam int DEV_SETUP_NS    = 20;
	localparam int DEV_STROBE_NS   = 100;
	localparam int DEV_RECOVER_NS  = 50;
	localparam int DEV_SETUP_CYC   = (DEV_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DEV_STROBE_CYC  = (DEV_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DEV_RECOVER_CYC = (DEV_RECOVER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int INIT_LAST_STEP  = 10;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'b0000,
		ST_INIT    = 4'b0001,
		ST_JOIN    = 4'b0010,
		ST_JOINCLR = 4'b0011,
		ST_ON      = 4'b0100,
		ST_SENDSET = 4'b0101,
		ST_SENDWT  = 4'b0110,
		ST_TXWAIT  = 4'b0111,
		ST_TXWR    = 4'b1000,
		ST_TXCLR   = 4'b1001,
		ST_TXEMPTY = 4'b1010,
		ST_LVCLR   = 4'b1011,
		ST_LVWAIT  = 4'b1100,
		ST_LVEXIT  = 4'b1101,
		ST_LVOFF   = 4'b1110
	} slc_state_t;

	typedef enum logic [1:0] {
		PH_IDLE    = 2'b00,
		PH_SETUP   = 2'b01,
		PH_STROBE  = 2'b10,
		PH_RECOVER = 2'b11
	} slc_phase_t;

endpackage : slc_pkg

// File: verilog/slc_dev_port.sv
`timescale 1ns/1ps
module slc_dev_port (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       go_i,
	input  wire logic       we_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	output logic            done_o,
	output logic [7:0]      rdata_o,
	output logic [3:0]      dev_addr_o,
	output logic [7:0]      dev_data_o,
	output logic            dev_wr_o,
	output logic            dev_rd_o,
	input  wire logic [7:0] dev_data_i
);

	slc_pkg::slc_phase_t ph_q;
	logic [7:0]          cnt_q;
	logic [7:0]          sync1_q;
	logic [7:0]          sync2_q;
	logic                we_q;

	// Read data crosses from the pins through two stages
	always_ff @(posedge clk_i) begin
		sync1_q <= dev_data_i;
		sync2_q <= sync1_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_q       <= slc_pkg::PH_IDLE;
			cnt_q      <= 8'h00;
			we_q       <= 1'b0;
			done_o     <= 1'b0;
			rdata_o    <= 8'h00;
			dev_addr_o <= 4'h0;
			dev_data_o <= 8'h00;
			dev_wr_o   <= 1'b0;
			dev_rd_o   <= 1'b0;
		end else begin
			done_o <= 1'b0;
			case (ph_q)
				slc_pkg::PH_IDLE: begin
					if (go_i) begin
						dev_addr_o <= addr_i;
						dev_data_o <= wdata_i;
						we_q       <= we_i;
						cnt_q      <= 8'(slc_pkg::DEV_SETUP_CYC);
						ph_q       <= slc_pkg::PH_SETUP;
					end
				end
				slc_pkg::PH_SETUP: begin
					if (cnt_q == 8'h01) begin
						dev_wr_o <= we_q;
						dev_rd_o <= ~we_q;
						cnt_q    <= 8'(slc_pkg::DEV_STROBE_CYC);
						ph_q     <= slc_pkg::PH_STROBE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				slc_pkg::PH_STROBE: begin
					if (cnt_q == 8'h01) begin
						// Sampled late in the strobe so the sync delay is covered
						rdata_o  <= sync2_q;
						dev_wr_o <= 1'b0;
						dev_rd_o <= 1'b0;
						cnt_q    <= 8'(slc_pkg::DEV_RECOVER_CYC);
						ph_q     <= slc_pkg::PH_RECOVER;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				slc_pkg::PH_RECOVER: begin
					if (cnt_q == 8'h01) begin
						done_o <= 1'b1;
						ph_q   <= slc_pkg::PH_IDLE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				default: begin
					ph_q <= slc_pkg::PH_IDLE;
				end
			endcase
		end
	end

endmodule : slc_dev_port

// File: verilog/slc_loop_ctl.sv
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
module slc_loop_ctl (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	output logic [3:0]       dev_addr_o,
	output logic [7:0]       dev_data_o,
	output logic             dev_wr_o,
	output logic             dev_rd_o,
	input  wire logic [7:0]  dev_data_i
);

	slc_pkg::slc_state_t st_q;
	logic [9:0]          cfg_q;
	logic [7:0]          staddr_q;
	logic [7:0]          flag_q;
	logic [7:0]          txd_q;
	logic                txlast_q;
	logic                txpend_q;
	logic                cmd_init_q;
	logic                cmd_send_q;
	logic                cmd_leave_q;
	logic                pend_q;
	logic                go_q;
	logic                we_q;
	logic [3:0]          addr_q;
	logic [7:0]          wdata_q;
	logic [3:0]          step_q;
	logic                sel_q;
	logic                seen_q;
	logic                first_q;
	logic                lastwr_q;
	logic [7:0]          pst_q;
	logic [7:0]          mst_q;
	logic                done;
	logic [7:0]          rdata;
	logic [7:0]          misc_base;
	logic [7:0]          rxp_val;
	logic [7:0]          txp_val;
	logic [7:0]          init_addr;
	logic [7:0]          init_data;
	logic                wb_req;
	logic                wb_wr;
	logic                tx_take;

	// Misc control with poll and loop cleared; reserved bits zero
	assign misc_base = {cfg_q[0], cfg_q[2:1], 1'b0, cfg_q[3], 1'b0, 1'b0, 1'b0};
	assign rxp_val   = {cfg_q[5:4], 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	assign txp_val   = {cfg_q[8], cfg_q[7:6], 1'b0, 1'b0, 1'b0, cfg_q[9], 1'b1};
	assign wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr     = wb_req & wb_we_i;
	assign tx_take   = (st_q == slc_pkg::ST_TXWR) & pend_q & done;

	// Setup order: mode, misc, flag, rx, tx, address, rx on, loop, tx on, CRC, poll
	always_comb begin
		init_addr = {4'h0, slc_pkg::DEV_MODE};
		init_data = slc_pkg::MODE_LOOP_VAL;
		case (step_q)
			4'd0: begin
				init_addr = {4'h0, slc_pkg::DEV_MODE};
				init_data = slc_pkg::MODE_LOOP_VAL;
			end
			4'd1: begin
				init_addr = {4'h0, slc_pkg::DEV_MISC};
				init_data = misc_base;
			end
			4'd2: begin
				init_addr = {4'h0, slc_pkg::DEV_FLAGPAT};
				init_data = flag_q;
			end
			4'd3: begin
				init_addr = {4'h0, slc_pkg::DEV_RXPAR};
				init_data = rxp_val;
			end
			4'd4: begin
				init_addr = {4'h0, slc_pkg::DEV_TXPAR};
				init_data = txp_val;
			end
			4'd5: begin
				init_addr = {4'h0, slc_pkg::DEV_STADDR};
				init_data = staddr_q;
			end
			4'd6: begin
				init_addr = {4'h0, slc_pkg::DEV_RXPAR};
				init_data = rxp_val | (8'h01 << slc_pkg::RXP_ENABLE);
			end
			4'd7: begin
				init_addr = {4'h0, slc_pkg::DEV_MISC};
				init_data = misc_base | (8'h01 << slc_pkg::MISC_LOOP);
			end
			4'd8: begin
				init_addr = {4'h0, slc_pkg::DEV_TXPAR};
				init_data = txp_val | (8'h01 << slc_pkg::TXP_ENABLE);
			end
			4'd9: begin
				init_addr = {4'h0, slc_pkg::DEV_CMD};
				init_data = slc_pkg::CMD_RST_TXCRC;
			end
			4'd10: begin
				init_addr = {4'h0, slc_pkg::DEV_MISC};
				init_data = misc_base | (8'h01 << slc_pkg::MISC_LOOP)
					| (8'h01 << slc_pkg::MISC_POLL);
			end
			default: begin
				init_addr = {4'h0, slc_pkg::DEV_MODE};
				init_data = slc_pkg::MODE_LOOP_VAL;
			end
		endcase
	end

	// Wishbone slave: ack one cycle after the request, unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req & ~wb_we_i) begin
				case (wb_adr_i)
					slc_pkg::WB_CFG:    wb_dat_o <= {22'h00_0000, cfg_q};
					slc_pkg::WB_ADDR:   wb_dat_o <= {16'h0000, flag_q, staddr_q};
					slc_pkg::WB_TXDATA: wb_dat_o <= {22'h00_0000, txpend_q, txlast_q, txd_q};
					slc_pkg::WB_STATUS: wb_dat_o <= {mst_q, pst_q, 6'h00,
						txpend_q, (st_q != slc_pkg::ST_IDLE) & (st_q != slc_pkg::ST_ON),
						pst_q[slc_pkg::PST_HUNT], pst_q[slc_pkg::PST_BREAK],
						mst_q[slc_pkg::MST_SENDING], mst_q[slc_pkg::MST_ONLOOP], st_q};
					default:            wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q    <= slc_pkg::CFG_RESET_VAL;
			staddr_q <= 8'h00;
			flag_q   <= slc_pkg::FLAG_RESET_VAL;
		end else if (wb_wr) begin
			if (wb_adr_i == slc_pkg::WB_CFG) begin
				if (wb_sel_i[0]) cfg_q[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1]) cfg_q[9:8] <= wb_dat_i[9:8];
			end
			if (wb_adr_i == slc_pkg::WB_ADDR) begin
				if (wb_sel_i[0]) staddr_q <= wb_dat_i[7:0];
				if (wb_sel_i[1]) flag_q <= wb_dat_i[15:8];
			end
		end
	end

	// Pending byte: a new write wins over the take in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			txd_q    <= 8'h00;
			txlast_q <= 1'b0;
			txpend_q <= 1'b0;
		end else if (wb_wr & (wb_adr_i == slc_pkg::WB_TXDATA) & wb_sel_i[0]) begin
			txd_q    <= wb_dat_i[7:0];
			txlast_q <= wb_sel_i[1] & wb_dat_i[slc_pkg::TXD_LAST];
			txpend_q <= 1'b1;
		end else if (tx_take) begin
			txpend_q <= 1'b0;
		end
	end

	// Command bits held until the sequencer consumes them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_init_q  <= 1'b0;
			cmd_send_q  <= 1'b0;
			cmd_leave_q <= 1'b0;
		end else if (wb_wr & (wb_adr_i == slc_pkg::WB_CTRL) & wb_sel_i[0]) begin
			cmd_init_q  <= cmd_init_q | wb_dat_i[slc_pkg::CTRL_INIT];
			cmd_send_q  <= cmd_send_q | wb_dat_i[slc_pkg::CTRL_SEND];
			cmd_leave_q <= cmd_leave_q | wb_dat_i[slc_pkg::CTRL_LEAVE];
		end else begin
			if (st_q == slc_pkg::ST_IDLE) cmd_init_q <= 1'b0;
			// Only consumed between polls, else a send during a poll is lost
			if (st_q == slc_pkg::ST_ON & ~pend_q & ~cmd_leave_q) cmd_send_q <= 1'b0;
			if (st_q == slc_pkg::ST_ON & ~pend_q) cmd_leave_q <= 1'b0;
		end
	end

	// Sequencer: each state except IDLE and TXWAIT issues one device access (ON only with no send or leave pending), acts when it is done
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q     <= slc_pkg::ST_IDLE;
			pend_q   <= 1'b0;
			go_q     <= 1'b0;
			we_q     <= 1'b0;
			addr_q   <= 4'h0;
			wdata_q  <= 8'h00;
			step_q   <= 4'h0;
			sel_q    <= 1'b0;
			seen_q   <= 1'b0;
			first_q  <= 1'b0;
			lastwr_q <= 1'b0;
			pst_q    <= 8'h00;
			mst_q    <= 8'h00;
		end else begin
			go_q <= 1'b0;
			if (done & ~we_q) begin
				if (addr_q == slc_pkg::DEV_PSTAT) pst_q <= rdata;
				else mst_q <= rdata;
			end
			case (st_q)
				slc_pkg::ST_IDLE: begin
					if (cmd_init_q) begin
						step_q <= 4'h0;
						st_q   <= slc_pkg::ST_INIT;
					end
				end
				slc_pkg::ST_INIT: begin
					if (~pend_q) begin
						go_q    <= 1'b1;
						pend_q  <= 1'b1;
						we_q    <= 1'b1;
						addr_q  <= init_addr[3:0];
						wdata_q <= init_data;
					end else if (done) begin
						pend_q <= 1'b0;
						if (step_q == 4'(slc_pkg::INIT_LAST_STEP)) st_q <= slc_pkg::ST_JOIN;
						else step_q <= step_q + 4'h1;
					end
				end
				slc_pkg::ST_JOIN: begin
					if (~pend_q) begin
						go_q   <= 1'b1;
						pend_q <= 1'b1;
						we_q   <= 1'b0;
						addr_q <= sel_q ? slc_pkg::DEV_PSTAT : slc_pkg::DEV_MSTAT;
					end else if (done) begin
						pend_q <= 1'b0;
						sel_q  <= ~sel_q;
						if (~sel_q & rdata[slc_pkg::MST_ONLOOP]) begin
							sel_q <= 1'b0;
							st_q  <= slc_pkg::ST_JOINCLR;
						end
					end
				end
				slc_pkg::ST_JOINCLR, slc_pkg::ST_TXCLR, slc_pkg::ST_LVCLR: begin
					// Poll activation off, loop kept
					if (~pend_q) begin
						go_q    <= 1'b1;
						pend_q  <= 1'b1;
						we_q    <= 1'b1;
						addr_q  <= slc_pkg::DEV_MISC;
						wdata_q <= misc_base | (8'h01 << slc_pkg::MISC_LOOP);
					end else if (done) begin
						pend_q <= 1'b0;
						case (st_q)
							slc_pkg::ST_TXCLR: st_q <= slc_pkg::ST_TXEMPTY;
							slc_pkg::ST_LVCLR: st_q <= slc_pkg::ST_LVWAIT;
							default:           st_q <= slc_pkg::ST_ON;
						endcase
					end
				end
				slc_pkg::ST_ON: begin
					// Keeps status fresh while idle on the loop
					if (~pend_q) begin
						if (cmd_leave_q) begin
							st_q <= slc_pkg::ST_LVCLR;
						end else if (cmd_send_q) begin
							st_q <= slc_pkg::ST_SENDSET;
						end else begin
							go_q   <= 1'b1;
							pend_q <= 1'b1;
							we_q   <= 1'b0;
							addr_q <= sel_q ? slc_pkg::DEV_PSTAT : slc_pkg::DEV_MSTAT;
						end
					end else if (done) begin
						pend_q <= 1'b0;
						sel_q  <= ~sel_q;
					end
				end
				slc_pkg::ST_SENDSET: begin
					if (~pend_q) begin
						go_q    <= 1'b1;
						pend_q  <= 1'b1;
						we_q    <= 1'b1;
						addr_q  <= slc_pkg::DEV_MISC;
						wdata_q <= misc_base | (8'h01 << slc_pkg::MISC_LOOP)
							| (8'h01 << slc_pkg::MISC_POLL);
					end else if (done) begin
						pend_q <= 1'b0;
						seen_q <= 1'b0;
						sel_q  <= 1'b1;
						st_q   <= slc_pkg::ST_SENDWT;
					end
				end
				slc_pkg::ST_SENDWT: begin
					if (~pend_q) begin
						go_q   <= 1'b1;
						pend_q <= 1'b1;
						we_q   <= 1'b0;
						addr_q <= sel_q ? slc_pkg::DEV_PSTAT : slc_pkg::DEV_MSTAT;
					end else if (done) begin
						pend_q <= 1'b0;
						sel_q  <= ~sel_q;
						if (sel_q & rdata[slc_pkg::PST_BREAK] & rdata[slc_pkg::PST_HUNT])
							seen_q <= 1'b1;
						if (~sel_q & seen_q & rdata[slc_pkg::MST_SENDING]) begin
							first_q <= 1'b1;
							st_q    <= slc_pkg::ST_TXWAIT;
						end
					end
				end
				slc_pkg::ST_TXWAIT: begin
					if (txpend_q) st_q <= slc_pkg::ST_TXWR;
				end
				slc_pkg::ST_TXWR: begin
					if (~pend_q) begin
						go_q     <= 1'b1;
						pend_q   <= 1'b1;
						we_q     <= 1'b1;
						addr_q   <= slc_pkg::DEV_TXBUF;
						wdata_q  <= txd_q;
						lastwr_q <= txlast_q;
					end else if (done) begin
						pend_q  <= 1'b0;
						first_q <= 1'b0;
						st_q    <= first_q ? slc_pkg::ST_TXCLR : slc_pkg::ST_TXEMPTY;
					end
				end
				slc_pkg::ST_TXEMPTY: begin
					if (~pend_q) begin
						go_q   <= 1'b1;
						pend_q <= 1'b1;
						we_q   <= 1'b0;
						addr_q <= slc_pkg::DEV_PSTAT;
					end else if (done) begin
						pend_q <= 1'b0;
						if (rdata[slc_pkg::PST_TXEMPTY])
							st_q <= lastwr_q ? slc_pkg::ST_ON : slc_pkg::ST_TXWAIT;
					end
				end
				slc_pkg::ST_LVWAIT, slc_pkg::ST_LVOFF: begin
					if (~pend_q) begin
						go_q   <= 1'b1;
						pend_q <= 1'b1;
						we_q   <= 1'b0;
						addr_q <= slc_pkg::DEV_MSTAT;
					end else if (done) begin
						pend_q <= 1'b0;
						if (st_q == slc_pkg::ST_LVWAIT & ~rdata[slc_pkg::MST_SENDING])
							st_q <= slc_pkg::ST_LVEXIT;
						if (st_q == slc_pkg::ST_LVOFF & ~rdata[slc_pkg::MST_ONLOOP])
							st_q <= slc_pkg::ST_IDLE;
					end
				end
				slc_pkg::ST_LVEXIT: begin
					if (~pend_q) begin
						go_q    <= 1'b1;
						pend_q  <= 1'b1;
						we_q    <= 1'b1;
						addr_q  <= slc_pkg::DEV_MISC;
						wdata_q <= misc_base;
					end else if (done) begin
						pend_q <= 1'b0;
						st_q   <= slc_pkg::ST_LVOFF;
					end
				end
				default: begin
					st_q <= slc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	slc_dev_port u_port (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.go_i       (go_q),
		.we_i       (we_q),
		.addr_i     (addr_q),
		.wdata_i    (wdata_q),
		.done_o     (done),
		.rdata_o    (rdata),
		.dev_addr_o (dev_addr_o),
		.dev_data_o (dev_data_o),
		.dev_wr_o   (dev_wr_o),
		.dev_rd_o   (dev_rd_o),
		.dev_data_i (dev_data_i)
	);

endmodule : slc_loop_ctl

// File: bench/slc_loop_ctl_properties.sv
`timescale 1ns/1ps
module slc_loop_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [3:0]  dev_addr_o,
	input wire logic [7:0]  dev_data_o,
	input wire logic        dev_wr_o,
	input wire logic        dev_rd_o,
	input wire logic [7:0]  dev_data_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic strobe;
	assign strobe = dev_wr_o || dev_rd_o;

	ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data not zero outside ack");
	strobe_excl_a: assert property (!(dev_wr_o && dev_rd_o))
		else $error("read and write strobes together");
	strobe_len_a: assert property ($rose(dev_wr_o) |->
		dev_wr_o[*8] ##1 dev_wr_o[*8] ##1 dev_wr_o[*4] ##1 !dev_wr_o)
		else $error("write strobe not twenty cycles");
	addr_hold_a: assert property (dev_wr_o && $past(dev_wr_o) |->
		$stable(dev_addr_o) && $stable(dev_data_o))
		else $error("device address or data moved in strobe");
	strobe_recover_a: assert property ($fell(strobe) |-> !strobe[*8])
		else $error("device recovery too short");
	mode_value_a: assert property (dev_wr_o && dev_addr_o == slc_pkg::DEV_MODE |->
		dev_data_o == slc_pkg::MODE_LOOP_VAL)
		else $error("mode register value wrong");
	crc_cmd_a: assert property (dev_wr_o && dev_addr_o == slc_pkg::DEV_CMD |->
		dev_data_o == slc_pkg::CMD_RST_TXCRC)
		else $error("command register value wrong");
	misc_resv_a: assert property (dev_wr_o && dev_addr_o == slc_pkg::DEV_MISC |->
		!dev_data_o[2] && !dev_data_o[0])
		else $error("misc reserved bits set");
	rx_value_a: assert property (dev_wr_o && dev_addr_o == slc_pkg::DEV_RXPAR |->
		dev_data_o[5:1] == 5'h0E)
		else $error("receive parameters wrong");

	cover property (wb_ack_o && !wb_we_i);
	cover property (dev_wr_o && dev_addr_o == slc_pkg::DEV_MISC && dev_data_o[4]);
	cover property (dev_rd_o && dev_addr_o == slc_pkg::DEV_MSTAT);
endmodule : slc_loop_props

bind slc_loop_ctl slc_loop_props i_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
	.wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_addr_o(dev_addr_o),
	.dev_data_o(dev_data_o), .dev_wr_o(dev_wr_o), .dev_rd_o(dev_rd_o), .dev_data_i(dev_data_i));

// File: bench/slc_dev_model.sv
`timescale 1ns/1ps
module slc_dev_model (
	input  wire logic       clk_i,
	input  wire logic       link_clk_i,
	input  wire logic       rxd_i,
	input  wire logic [3:0] dev_addr_i,
	input  wire logic [7:0] dev_data_i,
	input  wire logic       dev_wr_i,
	input  wire logic       dev_rd_i,
	output logic [7:0]      dev_data_o
);
	logic [7:0] regs [16];
	logic [3:0] log_a [$];
	logic [7:0] log_d [$];
	logic [2:0] ones_q = 3'h0;
	logic       on_q = 1'b0;
	logic       send_q = 1'b0;
	logic       brk_q = 1'b0;
	logic       hunt_q = 1'b0;
	logic       txw_q = 1'b0;
	logic       rd_q = 1'b0;
	logic [7:0] snap_q = 8'h00;
	logic       eop;
	assign eop = rxd_i && ones_q == 3'h6;

	initial for (int i = 0; i < 16; i++) regs[i] = 8'h00;

	// Idle and underrun choices only stored
	always @(negedge dev_wr_i) begin
		regs[dev_addr_i] = dev_data_i;
		log_a.push_back(dev_addr_i);
		log_d.push_back(dev_data_i);
		if (dev_addr_i == slc_pkg::DEV_TXBUF) txw_q = 1'b1;
	end

	always @(posedge link_clk_i) begin
		ones_q <= !rxd_i ? 3'h0 : (ones_q == 3'h7 ? 3'h7 : ones_q + 3'h1);
		if (send_q) txw_q = 1'b0;
		if (send_q && !txw_q && !regs[slc_pkg::DEV_MISC][slc_pkg::MISC_POLL]) send_q <= 1'b0;
		if (eop && regs[slc_pkg::DEV_MISC][slc_pkg::MISC_LOOP]) begin
			if (!on_q && regs[slc_pkg::DEV_MISC][slc_pkg::MISC_POLL]) begin
				on_q   <= 1'b1;
				brk_q  <= 1'b1;
				hunt_q <= 1'b1;
			end else if (on_q && regs[slc_pkg::DEV_MISC][slc_pkg::MISC_POLL]) begin
				send_q <= 1'b1;
				brk_q  <= 1'b1;
				hunt_q <= 1'b1;
			end
		end else if (eop && on_q) begin
			on_q   <= 1'b0;
			brk_q  <= 1'b1;
			hunt_q <= 1'b1;
		end
	end

	// Snapshot at strobe start keeps the byte steady
	always @(posedge clk_i) begin
		rd_q <= dev_rd_i;
		if (dev_rd_i && !rd_q)
			snap_q <= (dev_addr_i == slc_pkg::DEV_MSTAT) ? {3'h0, send_q, 2'h0, on_q, 1'b0}
				: {brk_q, 2'h0, hunt_q, 1'b0, !txw_q, 2'h0};
	end
	// Released bus shows the inverse so stale data cannot pass
	assign dev_data_o = dev_rd_i ? snap_q : ~snap_q;
endmodule : slc_dev_model

// File: bench/slc_loop_ctl_tb.sv
`timescale 1ns/1ps
module slc_loop_ctl_tb;
	typedef struct {logic [7:0] adr; logic [31:0] dat; logic [3:0] sel; logic [31:0] exp;} slc_row_t;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        link_clk = 1'b0;
	logic        line_en = 1'b0;
	logic [4:0]  lbit_q = 5'h00;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [3:0]  sel = 4'h0;
	logic [31:0] rdat;
	logic        ack;
	logic [3:0]  dev_addr;
	logic [7:0]  dev_wdata;
	logic [7:0]  dev_rdata;
	logic        dev_wr;
	logic        dev_rd;
	logic [31:0] stat;
	int          err_total = 0;
	int          checks = 0;
	int          cycles = 0;
	slc_row_t    rows [5] = '{
		'{slc_pkg::WB_CFG, 32'h0000_02B5, 4'hF, 32'h0000_02B5},
		'{slc_pkg::WB_ADDR, 32'h0000_115A, 4'h1, 32'h0000_7E5A},
		'{8'h20, 32'hFFFF_FFFF, 4'hF, 32'h0},
		'{slc_pkg::WB_CTRL, 32'h0, 4'hF, 32'h0},
		'{slc_pkg::WB_STATUS, 32'hFFFF_FFFF, 4'hF, 32'h0}};
	logic [11:0] exp_log [17] = '{12'h420, 12'hAC0, 12'h77E, 12'h3DC, 12'h543, 12'h65A,
		12'h3DD, 12'hAC2, 12'h54B, 12'h080, 12'hAD2, 12'hAC2, 12'hAD2, 12'h8A5, 12'hAC2,
		12'hAC2, 12'hAC0};

	always #2.5 clk_i = ~clk_i;
	always #24 link_clk = ~link_clk;
	// One zero every 32 line bits gives a fresh seven-ones run
	always @(negedge link_clk) lbit_q <= lbit_q + 5'h01;

	slc_loop_ctl i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat),
		.wb_ack_o(ack), .dev_addr_o(dev_addr), .dev_data_o(dev_wdata), .dev_wr_o(dev_wr),
		.dev_rd_o(dev_rd), .dev_data_i(dev_rdata));
	slc_dev_model i_dev (.clk_i(clk_i), .link_clk_i(link_clk), .rxd_i(line_en && lbit_q != 5'h00),
		.dev_addr_i(dev_addr), .dev_data_i(dev_wdata), .dev_wr_i(dev_wr), .dev_rd_i(dev_rd),
		.dev_data_o(dev_rdata));

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		$display("Mismatches %0d in %0d checks", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
			input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		check("ack", {31'h0, ack}, 32'h1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask : wb

	task automatic wait_state(input logic [3:0] st);
		int n;
		n = 0;
		do begin
			wb(1'b0, slc_pkg::WB_STATUS, 32'h0, stat);
			n++;
		end while (stat[3:0] !== st && n < 3000);
		check("state", {28'h0, stat[3:0]}, {28'h0, st});
	endtask : wait_state

	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			give_verdict();
		end
	end

	initial begin
		logic [31:0] q;
		int n;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, slc_pkg::WB_CFG, 32'h0, q);
		check("cfg reset", q, {22'h0, slc_pkg::CFG_RESET_VAL});
		wb(1'b0, slc_pkg::WB_ADDR, 32'h0, q);
		check("flag reset", q, 32'h0000_7E00);
		foreach (rows[i]) begin
			wb(1'b1, rows[i].adr, rows[i].dat, q, rows[i].sel);
			wb(1'b0, rows[i].adr, 32'h0, q);
			check("row", q, rows[i].exp);
		end
		wb(1'b1, slc_pkg::WB_CTRL, 32'h1, q);
		wait_state(4'h2);
		// Dead line for several line periods: no join
		repeat (800) @(posedge clk_i);
		wait_state(4'h2);
		line_en <= 1'b1;
		wait_state(4'h4);
		// Status is a snapshot: let both device registers be polled again
		repeat (200) @(posedge clk_i);
		wb(1'b0, slc_pkg::WB_STATUS, 32'h0, stat);
		check("join flags", {28'h0, stat[7:4]}, 32'hD);
		wb(1'b1, slc_pkg::WB_TXDATA, 32'h1A5, q);
		wb(1'b0, slc_pkg::WB_TXDATA, 32'h0, q);
		check("tx pending", q, 32'h3A5);
		wb(1'b1, slc_pkg::WB_CTRL, 32'h2, q);
		n = 0;
		while (i_dev.log_a.size() < 15 && n < 20000) begin
			@(posedge clk_i);
			n++;
		end
		wait_state(4'h4);
		repeat (200) @(posedge clk_i);
		wb(1'b0, slc_pkg::WB_STATUS, 32'h0, stat);
		check("sent flags", {22'h0, stat[9:4]}, 32'hD);
		wb(1'b1, slc_pkg::WB_CTRL, 32'h4, q);
		wait_state(4'h0);
		check("left flags", {28'h0, stat[7:4]}, 32'hC);
		check("dev count", i_dev.log_a.size(), 32'd17);
		foreach (exp_log[i]) begin
			check("dev write", {20'h0, i_dev.log_a[i], i_dev.log_d[i]}, {20'h0, exp_log[i]});
		end
		wb(1'b1, slc_pkg::WB_CFG, 32'h0000_0155, q);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		wb(1'b0, slc_pkg::WB_CFG, 32'h0, q);
		check("cfg rereset", q, {22'h0, slc_pkg::CFG_RESET_VAL});
		give_verdict();
	end
endmodule : slc_loop_ctl_tb
